/* inc/rom_flash_pkg.sv */
// Constants for the boot ROM/Flash bank interface.
// Assumes a single 10 MHz clock and straps sampled while reset is held.
package rom_flash_pkg;

   // ----------------------------------------
   // Address map
   // ----------------------------------------
   localparam logic [7:0] ROM_SPACE_TOP8 = 8'hff;
   localparam int BANK_SEL_BIT = 23;
   localparam int ROM_ADDR_W = 21;
   localparam int ADDR_W_64 = 20;
   localparam int MAX_GATHER = 8;

   // ----------------------------------------
   // Width codes and states
   // ----------------------------------------
   typedef enum logic [1:0] {
      WIDTH_8 = 2'h0,
      WIDTH_32 = 2'h1,
      WIDTH_64 = 2'h2
   } width_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_READ = 4'h2,
      ST_WRITE = 4'h4,
      ST_DONE = 4'h8
   } state_t;

   localparam logic [7:0] ACCESS_CYCLES = 8'h04;
   localparam logic [3:0] LANES_8 = 4'h1;
   localparam logic [3:0] LANES_32 = 4'h4;
   localparam logic [3:0] LANES_64 = 4'h8;

endpackage

/* inc/gather_if.sv */
// Byte gathering carrier between the controller and the gather buffer.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
interface gather_if;
   logic clear;
   logic load;
   logic [2:0] lane;
   logic [7:0] byte_in;
   logic [63:0] word;
   modport ctrl (output clear, output load, output lane, output byte_in,
      input word);
   modport buf_side (input clear, input load, input lane, input byte_in,
      output word);
endinterface

/* verilog/rom_gather_buffer.sv */
// Eight-byte gather register that assembles narrow ROM reads.
// Assumes the controller clears it before each access.
`timescale 1ns/1ns
module rom_gather_buffer (
   input wire logic i_clock,
   input wire logic i_reset_n,
   gather_if.buf_side g
);
   logic [63:0] word_q;

   // ----------------------------------------
   // Byte lanes
   // ----------------------------------------
   genvar k;
   generate
      for (k = 0; k < 8; k++) begin : g_lane
         always_ff @(posedge i_clock) begin
            if (!i_reset_n || g.clear) begin
               word_q[63-8*k -: 8] <= 8'h00;
            end else if (g.load && g.lane == 3'(k)) begin
               word_q[63-8*k -: 8] <= g.byte_in;
            end
         end
      end
   endgenerate

   assign g.word = word_q;
endmodule // rom_gather_buffer

/* verilog/rom_flash_bank_interface.sv */
// Boot ROM/Flash bank interface: decode, strap capture, pin mapping,
// byte gathering. Assumes data pins and straps come from outside the
// clock domain; requests come from logic on the same clock.
// Functional notes
// [RULE_01] Drive 21 address lines, two low-active bank selects, OE and WE.
// [RULE_02] In 64-bit mode AR19..12 go on parity pins, AR11 on bank pin 0.
// [RULE_03] In 32-bit mode AR20 additionally goes on the shared top pin.
// [RULE_04] The read strobe strap at reset picks bank 0 width 8/32/64.
// [RULE_05] The lane-0 strap at reset picks bank 1 width 64 or 32 only.
// [RULE_06] Strap pairs 00,01,1x map to 32/32, 64/64, 8/bank1-by-lane.
// [RULE_07] The 21st address bit is used for 8-bit bank 0 and 32-bit banks.
// [RULE_08] With the lane strap high no 32-bit ROM width exists.
// [RULE_09] An 8-bit ROM sits on the top byte lane of the high data word.
// [RULE_10] An 8-bit system supplies its own decode between two devices.
// [RULE_11] A single-byte read is shifted to the lane its address expects.
// [RULE_12] Up to eight narrow bytes are gathered before data is returned.
// [RULE_13] 0xff800000+ selects bank 0, 0xff000000-0xff7fffff bank 1.
// [RULE_14] Unfitted parts of a bank alias onto the fitted device.
// [RULE_15] The bank 0 select strap at reset may send all ROM to PCI.
// [RULE_16] With ROM on PCI, the local bit returns the lower half to bank 1.
// [RULE_17] WE only on writes, OE only on reads, never both.
`timescale 1ns/1ns
module rom_flash_bank_interface
   import rom_flash_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_flash_read_strobe_strap,
   input wire logic i_low_lane0_width_strap,
   input wire logic i_rom_bank0_select_strap,
   input wire logic i_lower_rom_half_local_bit,
   input wire logic i_req_valid,
   input wire logic i_req_write,
   input wire logic [31:0] i_req_addr,
   input wire logic [3:0] i_req_size,
   input wire logic [7:0] i_req_wdata,
   input wire logic [63:0] i_mem_data,
   output logic o_req_ready,
   output logic o_resp_valid,
   output logic [63:0] o_resp_data,
   output logic o_pci_valid,
   output logic [31:0] o_pci_addr,
   output logic o_pci_write,
   output logic o_rom_bank0_select_n,
   output logic o_rom_bank1_select_n,
   output logic o_rom_read_strobe_n,
   output logic o_rom_write_strobe_n,
   output logic [7:0] o_parity_pins_high_addr,
   output logic o_bank_addr_pin0,
   output logic [10:0] o_mem_addr_pins_low,
   output logic o_shared_top_addr_pin,
   output logic [7:0] o_wdata,
   output logic o_wdata_oe
);

   // ----------------------------------------
   // Pin synchronisers and reset straps
   // ----------------------------------------
   logic [2:0] strap_meta_q, strap_sync_q;
   logic [63:0] data_meta_q, data_sync_q;
   logic strap_oe_q, strap_lane_q, strap_pci_q;
   width_t width0_q, width1_q;

   always_ff @(posedge i_clock) begin
      strap_meta_q <= {i_rom_bank0_select_strap, i_low_lane0_width_strap,
         i_flash_read_strobe_strap};
      strap_sync_q <= strap_meta_q;
      data_meta_q <= i_mem_data;
      data_sync_q <= data_meta_q;
   end

   // Straps follow the pins while reset is held and freeze on release
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         strap_oe_q <= strap_sync_q[0]; // see [RULE_04]
         strap_lane_q <= strap_sync_q[1]; // see [RULE_05]
         strap_pci_q <= strap_sync_q[2]; // see [RULE_15]
      end
   end

   // Lane strap high never yields 32-bit ROM; bank 1 never 8-bit
   always_comb begin
      width1_q = strap_lane_q ? WIDTH_64 : WIDTH_32; // see [RULE_05]
      if (strap_oe_q) begin
         width0_q = WIDTH_8; // see [RULE_06]
      end else begin
         width0_q = strap_lane_q ? WIDTH_64 : WIDTH_32; // see [RULE_08]
      end
   end

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   logic in_rom, hi_half, to_pci;
   assign in_rom = i_req_addr[31:24] == ROM_SPACE_TOP8;
   assign hi_half = i_req_addr[BANK_SEL_BIT]; // see [RULE_13]
   // Lower half returns to the memory bus only when ROM sits on PCI
   assign to_pci = strap_pci_q &&
      !(i_lower_rom_half_local_bit && !hi_half); // see [RULE_15] [RULE_16]

   // ----------------------------------------
   // Access sequencer
   // ----------------------------------------
   state_t state_q;
   logic bank_hi_q, write_q;
   logic [20:0] ar_q;
   logic [7:0] wait_q;
   logic [3:0] beats_q, beat_q;
   logic [2:0] lane0_q;
   width_t width_q;
   gather_if g ();

   rom_gather_buffer u_gather (
      .i_clock(i_clock),
      .i_reset_n(i_reset_n),
      .g(g)
   );

   assign o_req_ready = state_q == ST_IDLE;

   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         state_q <= ST_IDLE;
         bank_hi_q <= 1'b0;
         write_q <= 1'b0;
         ar_q <= 21'h000000;
         wait_q <= 8'h00;
         beats_q <= 4'h0;
         beat_q <= 4'h0;
         lane0_q <= 3'h0;
         width_q <= WIDTH_64;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (i_req_valid && in_rom && !to_pci) begin
                  bank_hi_q <= hi_half;
                  write_q <= i_req_write;
                  width_q <= hi_half ? width0_q : width1_q;
                  lane0_q <= i_req_addr[2:0];
                  wait_q <= ACCESS_CYCLES;
                  beat_q <= 4'h0;
                  // High address bits beyond the device simply alias
                  unique case (hi_half ? width0_q : width1_q) // see [RULE_14]
                     WIDTH_8: begin
                        ar_q <= i_req_addr[20:0]; // see [RULE_07]
                        beats_q <= i_req_write ? 4'h1 :
                           ((i_req_size > LANES_64) ? LANES_64 :
                           (i_req_size == 4'h0 ? 4'h1 : i_req_size));
                     end
                     WIDTH_32: begin
                        ar_q <= {i_req_addr[22:3], 1'b0}; // see [RULE_07]
                        beats_q <= 4'h1;
                     end
                     default: begin
                        ar_q <= {1'b0, i_req_addr[22:3]};
                        beats_q <= 4'h1;
                     end
                  endcase
                  state_q <= i_req_write ? ST_WRITE : ST_READ;
               end
            end
            ST_READ: begin
               if (wait_q == 8'h01) begin
                  wait_q <= ACCESS_CYCLES;
                  beat_q <= beat_q + 4'h1;
                  ar_q <= ar_q + 21'h000001;
                  if (beat_q + 4'h1 == beats_q) begin // see [RULE_12]
                     state_q <= ST_DONE;
                  end
               end else begin
                  wait_q <= wait_q - 8'h01;
               end
            end
            ST_WRITE: begin
               if (wait_q == 8'h01) begin
                  state_q <= ST_DONE;
               end else begin
                  wait_q <= wait_q - 8'h01;
               end
            end
            ST_DONE: state_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Gathering and lane alignment
   // ----------------------------------------
   logic sample;
   logic [3:0] lane_sum;
   assign sample = state_q == ST_READ && wait_q == 8'h01;
   assign lane_sum = {1'b0, lane0_q} + beat_q;
   assign g.clear = state_q == ST_IDLE;
   assign g.load = sample && width_q == WIDTH_8;
   assign g.lane = lane_sum[2:0]; // see [RULE_11]
   assign g.byte_in = data_sync_q[63:56]; // see [RULE_09]

   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         o_resp_valid <= 1'b0;
         o_resp_data <= 64'h0;
      end else begin
         o_resp_valid <= state_q == ST_DONE && !write_q;
         // Wide reads were latched at sampling; only gathered bytes land here
         if (state_q == ST_DONE && !write_q && width_q == WIDTH_8) begin
            o_resp_data <= g.word; // see [RULE_12]
         end else if (sample && width_q != WIDTH_8) begin
            // 32-bit parts sit on the high word; other half reads zero
            o_resp_data <= (width_q == WIDTH_32) ?
               {data_sync_q[63:32], 32'h0} : data_sync_q;
         end
      end
   end

   // ----------------------------------------
   // PCI routing
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         o_pci_valid <= 1'b0;
         o_pci_addr <= 32'h0;
         o_pci_write <= 1'b0;
      end else begin
         o_pci_valid <= o_req_ready && i_req_valid && in_rom && to_pci;
         o_pci_addr <= i_req_addr;
         o_pci_write <= i_req_write;
      end
   end

   // ----------------------------------------
   // Pins
   // ----------------------------------------
   logic active;
   assign active = state_q == ST_READ || state_q == ST_WRITE;
   assign o_rom_bank0_select_n = !(active && bank_hi_q); // see [RULE_01]
   assign o_rom_bank1_select_n = !(active && !bank_hi_q); // see [RULE_13]
   assign o_rom_read_strobe_n = !(state_q == ST_READ); // see [RULE_17]
   assign o_rom_write_strobe_n = !(state_q == ST_WRITE); // see [RULE_17]
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         o_parity_pins_high_addr[i] = ar_q[19-i]; // see [RULE_02]
      end
   end
   assign o_bank_addr_pin0 = ar_q[11];
   assign o_mem_addr_pins_low = ar_q[10:0];
   assign o_shared_top_addr_pin =
      (width_q != WIDTH_64) && ar_q[20]; // see [RULE_03]
   assign o_wdata_oe = state_q == ST_WRITE;
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         o_wdata <= 8'h00;
      end else if (o_req_ready && i_req_valid) begin
         o_wdata <= i_req_wdata;
      end
   end

endmodule // rom_flash_bank_interface

/* testbench/rom_flash_bank_interface_props.sv */
// Pin and timing checks on the ROM/Flash bank interface top module.
// Assumes straps are steady while reset is held low.
`timescale 1ns/1ns
module rom_flash_bank_interface_props (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_flash_read_strobe_strap,
   input wire logic i_low_lane0_width_strap,
   input wire logic i_rom_bank0_select_strap,
   input wire logic i_lower_rom_half_local_bit,
   input wire logic i_req_valid,
   input wire logic [31:0] i_req_addr,
   input wire logic o_req_ready,
   input wire logic o_resp_valid,
   input wire logic o_pci_valid,
   input wire logic [31:0] o_pci_addr,
   input wire logic o_rom_bank0_select_n,
   input wire logic o_rom_bank1_select_n,
   input wire logic o_rom_read_strobe_n,
   input wire logic o_rom_write_strobe_n,
   input wire logic [7:0] o_parity_pins_high_addr,
   input wire logic o_bank_addr_pin0,
   input wire logic [10:0] o_mem_addr_pins_low,
   input wire logic o_shared_top_addr_pin
);
   logic foe_q, lane_q, pci_q, hit, to_pci, on, w64, w32, s0_n, s1_n, rd_n;
   logic [31:0] a_q;
   logic [7:0] par_r;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   assign s0_n = o_rom_bank0_select_n;
   assign s1_n = o_rom_bank1_select_n;
   assign rd_n = o_rom_read_strobe_n;
   assign hit = i_req_valid && o_req_ready && i_req_addr[31:24] == 8'hff;
   assign to_pci = pci_q && (i_req_addr[23] || !i_lower_rom_half_local_bit);
   assign on = !s0_n || !s1_n;
   // Pin 0 of the parity group carries the most significant bit
   assign par_r = {<<{o_parity_pins_high_addr}};
   assign w64 = s0_n ? lane_q : !foe_q && lane_q;
   assign w32 = s0_n ? !lane_q : !foe_q && !lane_q;
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         foe_q <= i_flash_read_strobe_strap;
         lane_q <= i_low_lane0_width_strap;
         pci_q <= i_rom_bank0_select_strap;
      end
   end
   always_ff @(posedge i_clock) begin
      if (hit) begin
         a_q <= i_req_addr;
      end
   end
   AST_STROBE_EXCL: assert property (rd_n ||
      o_rom_write_strobe_n)
      else $error("both strobes low");
   AST_BANK_SEL: assert property (hit && !to_pci |=>
      (a_q[23] ? !s0_n && s1_n : s0_n && !s1_n))
      else $error("wrong bank select");
   AST_PCI_ROUTE: assert property (hit && to_pci |=>
      o_pci_valid && o_pci_addr == a_q && s0_n && s1_n)
      else $error("rom access not sent to pci");
   AST_REFUSE: assert property (i_req_valid && o_req_ready &&
      i_req_addr[31:24] != 8'hff |=> o_req_ready && s0_n && s1_n)
      else $error("access outside rom space taken");
   AST_READ_HOLD: assert property ($fell(rd_n) |-> (!rd_n)[*4])
      else $error("read strobe too short");
   AST_RESP_AFTER: assert property ($rose(rd_n) |=>
      o_resp_valid)
      else $error("no response after read");
   AST_MAP_64: assert property (on && w64 |->
      {par_r, o_bank_addr_pin0, o_mem_addr_pins_low} == a_q[22:3] &&
      !o_shared_top_addr_pin)
      else $error("64-bit address pins wrong");
   AST_MAP_32: assert property (on && w32 |->
      {o_shared_top_addr_pin, par_r, o_bank_addr_pin0, o_mem_addr_pins_low}
      == {a_q[22:3], 1'b0})
      else $error("32-bit address pins wrong");
endmodule // rom_flash_bank_interface_props

bind rom_flash_bank_interface rom_flash_bank_interface_props props_i (.*);

/* testbench/rom_flash_model.sv */
// Behavioural ROM bank pair answering reads from the low address pins.
// Assumes one clock shared with the interface.
`timescale 1ns/1ns
module rom_flash_model (
   input wire logic i_clock,
   input wire logic i_bank0_n,
   input wire logic i_bank1_n,
   input wire logic i_read_n,
   input wire logic [7:0] i_addr,
   output logic [63:0] o_data
);
   logic [63:0] last_q = 64'h0;
   logic act;
   // Bank 1 data is inverted so a wrong select shows up in the data
   assign act = !i_read_n && !(i_bank0_n && i_bank1_n);
   // Released lanes invert each cycle so stale data never matches
   assign o_data = act ? {8{i_addr ^ {8{!i_bank1_n}}}} :
      ~last_q;
   always @(posedge i_clock) last_q <= o_data;
endmodule // rom_flash_model

/* testbench/rom_flash_bank_interface_tb_top.sv */
// Self-checking bench for the ROM/Flash bank interface.
// Assumes the ROM model and the bound checker stand beside the design.
`timescale 1ns/1ns
module rom_flash_bank_interface_tb_top;
   typedef struct {
      logic [3:0] cfg;
      logic [2:0] kind;
      logic [31:0] addr;
      logic [3:0] size;
      logic [63:0] exp;
   } row_t;
   row_t rows [14];
   logic clock = 0, reset_n = 0, flash_read_strobe_strap = 0, lane = 0, pci = 0, loc = 0;
   logic valid = 0, wr = 0, rdy, rv, pv, pw, s0_n, s1_n, rd_n, wr_n;
   logic ba0, top, oe;
   logic [31:0] addr = 0, pa;
   logic [3:0] size = 0;
   logic [7:0] par, wdo;
   logic [10:0] low;
   logic [63:0] mem, rd;
   int num_errors = 0, checks_done = 0;
   rom_flash_bank_interface dut (.i_clock(clock), .i_reset_n(reset_n),
      .i_flash_read_strobe_strap(flash_read_strobe_strap), .i_low_lane0_width_strap(lane),
      .i_rom_bank0_select_strap(pci), .i_lower_rom_half_local_bit(loc),
      .i_req_valid(valid), .i_req_write(wr), .i_req_addr(addr),
      .i_req_size(size), .i_req_wdata(8'h5a), .i_mem_data(mem),
      .o_req_ready(rdy), .o_resp_valid(rv), .o_resp_data(rd),
      .o_pci_valid(pv), .o_pci_addr(pa), .o_pci_write(pw),
      .o_rom_bank0_select_n(s0_n), .o_rom_bank1_select_n(s1_n),
      .o_rom_read_strobe_n(rd_n), .o_rom_write_strobe_n(wr_n),
      .o_parity_pins_high_addr(par), .o_bank_addr_pin0(ba0),
      .o_mem_addr_pins_low(low), .o_shared_top_addr_pin(top),
      .o_wdata(wdo), .o_wdata_oe(oe));
   rom_flash_model rom (.i_clock(clock), .i_bank0_n(s0_n), .i_bank1_n(s1_n),
      .i_read_n(rd_n), .i_addr(low[7:0]), .o_data(mem));
   initial forever #50 clock = ~clock;
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Straps need several edges to pass the synchronisers
   task automatic do_reset(input logic [3:0] c);
      @(posedge clock);
      reset_n <= 0;
      {flash_read_strobe_strap, lane, pci, loc} <= c;
      repeat (4) @(posedge clock);
      reset_n <= 1;
      @(posedge clock);
      #1;
      check({s0_n, s1_n, rd_n, wr_n, rv, pv}, 6'h3c);
   endtask
   task automatic run(input row_t r);
      int n;
      logic [63:0] got;
      got = 0;
      @(posedge clock);
      valid <= 1;
      wr <= r.kind == 3;
      addr <= r.addr;
      size <= r.size;
      @(posedge clock);
      valid <= 0;
      // The PCI pulse stands only in the cycle right after the take
      #1;
      for (n = 0; n < 60 && !(rv === 1 || pv === 1); n++) begin
         @(posedge clock);
         #1;
         if (wr_n === 0 && oe === 1) got = wdo;
      end
      case (r.kind)
         0: check(rd, r.exp);
         1: check({pw, pa}, r.exp);
         2: check(n, 60);
         3: check(got, r.exp);
         default: begin
            check(n < 60, 1);
            check(rd, r.exp);
         end
      endcase
      if (n == 60 && r.kind != 2 && r.kind != 3) begin
         num_errors++;
         $display("mismatch at %0t: no answer", $time);
         final_report();
      end
   endtask
   initial begin
      int n;
      rows = '{
         '{4'h4, 3'h0, 32'hff800008, 4'h1, {8{8'h01}}},
         '{4'h4, 3'h0, 32'hffc00008, 4'h1, {8{8'h01}}},
         '{4'h4, 3'h0, 32'hff000010, 4'h1, {8{8'hfd}}},
         '{4'hc, 3'h0, 32'hff800005, 4'h1, 64'h0000000000050000},
         '{4'hc, 3'h0, 32'hff800003, 4'h2, 64'h0000000304000000},
         '{4'hc, 3'h0, 32'hff800006, 4'h8, 64'h08090a0b0c0d0607},
         '{4'hc, 3'h0, 32'hff000008, 4'h1, {8{8'hfe}}},
         '{4'h6, 3'h1, 32'hff000000, 4'h1, 64'hff000000},
         '{4'h7, 3'h0, 32'hff000008, 4'h1, {8{8'hfe}}},
         '{4'h7, 3'h1, 32'hff800010, 4'h1, 64'hff800010},
         '{4'h4, 3'h2, 32'hfe000000, 4'h1, 64'h0},
         '{4'h4, 3'h3, 32'hff800000, 4'h1, 64'h5a},
         '{4'h0, 3'h4, 32'hff800018, 4'h1, 64'h0606060600000000},
         '{4'h8, 3'h4, 32'hff000018, 4'h1, 64'hf9f9f9f900000000}};
      foreach (rows[i]) begin
         do_reset(rows[i].cfg);
         run(rows[i]);
      end
      // A request held high while busy must be taken only between reads
      do_reset(4'h4);
      @(posedge clock);
      valid <= 1;
      wr <= 0;
      addr <= 32'hff800008;
      @(posedge clock);
      n = 0;
      repeat (14) begin
         @(posedge clock);
         #1;
         n += (rv === 1);
      end
      @(posedge clock);
      valid <= 0;
      check(n, 2);
      final_report();
   end
endmodule // rom_flash_bank_interface_tb_top
